// ===== hw/asp_pkg.sv
// asp_pkg: register map, field positions and state types of the port
// assumes: one clock domain, registers reached as AHB-Lite words
// What this block does
// - each character opens with one low start bit
// - one or two high stop bits, control bit 6
// - idle transmit level chosen by control bit 4
// - receive events raise the receive interrupt
// - control bit 7 gates receive interrupts
// - status bit 11 shows holding word moved out
// - status bit 12 shows holding and shifter empty
// - free and soft bits set breakpoint halt mode
// - receive line sampled bit by bit into shifter
// - holding register emptying raises transmit interrupt
// - control bit 8 gates transmit interrupts
// - status bit 9 flags overwritten unread character
// - all sources share one port interrupt line
package asp_pkg;
	// byte offsets of the word registers
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DATA = 8'h04;
	localparam logic [7:0] OFS_IOSTAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_STS = 8'h0C;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
	localparam logic [7:0] OFS_IRQ_EN = 8'h14;
	localparam logic [7:0] OFS_BAUD = 8'h18;
	// async_port_control fields
	localparam int CB_IDLE_LVL = 4;
	localparam int CB_STOP2 = 6;
	localparam int CB_RX_IM = 7;
	localparam int CB_TX_IM = 8;
	localparam int CB_PRST = 13;
	localparam int CB_SOFT = 14;
	localparam int CB_FREE = 15;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	// io_status_word fields
	localparam int SB_BRK = 5;
	localparam int SB_ABD = 6;
	localparam int SB_DRDY = 8;
	localparam int SB_OVR = 9;
	localparam int SB_FE = 10;
	localparam int SB_THE = 11;
	localparam int SB_TAE = 12;
	// sticky event bits, same layout in status, clear and enable
	localparam int IB_RXC = 0;
	localparam int IB_OVR = 1;
	localparam int IB_FE = 2;
	localparam int IB_BRK = 3;
	localparam int IB_ABD = 4;
	localparam int IB_TX = 5;
	localparam int IB_DLT = 6;
	localparam logic [6:0] IRQ_RX_SET = 7'h1F;
	localparam logic [6:0] IRQ_EN_RST = 7'h00;
	// bit time is divisor plus one clocks; default near 115200 baud
	localparam logic [15:0] BAUD_RST = 16'h0363;
	localparam logic [7:0] ABD_UPPER = 8'h41;
	localparam logic [7:0] ABD_LOWER = 8'h61;
	localparam logic [2:0] LAST_BIT = 3'h7;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10, TX_STOP = 2'b11
	} asp_tx_st_type;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11
	} asp_rx_st_type;
endpackage

// ===== hw/asp_rx_if.sv
// asp_rx_if: settings to the receiver and its character results
// assumes: both ends on hclk
`timescale 1ns/100ps
`default_nettype none
interface asp_rx_if;
	logic [15:0] div; // bit time minus one, in clocks
	logic two_stop; // expect a second stop bit
	logic run; // low freezes the framer; line filter and delta keep running
	logic clr; // port reset, back to idle
	logic char_valid; // one-cycle pulse per character
	logic [7:0] char_data;
	logic frame_err; // with char_valid
	logic brk; // with char_valid
	logic delta; // line level changed
	modport core (output div, two_stop, run, clr,
		input char_valid, char_data, frame_err, brk, delta);
	modport rcv (input div, two_stop, run, clr,
		output char_valid, char_data, frame_err, brk, delta);
endinterface
`default_nettype wire

// ===== hw/asp_rx.sv
// asp_rx: receive side, pin synchroniser and character framer
// assumes: rx_pin is asynchronous to hclk; settings held stable
`timescale 1ns/100ps
`default_nettype none
module asp_rx
	import asp_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic rx_pin,
	asp_rx_if.rcv rif
);
	logic [2:0] sync_q; // [0] first stage, read only by [1]
	logic lvl_q; // filtered line level
	asp_rx_st_type st_q;
	logic [15:0] cnt_q; // clocks to next sample
	logic [2:0] idx_q; // data bit index
	logic [7:0] sh_q; // async_rx_shifter
	logic stp_q; // second stop still to come
	logic fe_q; // first stop was low

	// three stages; level moves only when the last two agree
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_q <= 3'h7;
			lvl_q <= 1'b1;
			rif.delta <= 1'b0;
		end else if (ce) begin
			sync_q <= {sync_q[1:0], rx_pin};
			rif.delta <= 1'b0;
			if (sync_q[1] == sync_q[2] && sync_q[2] != lvl_q) begin
				lvl_q <= sync_q[2];
				rif.delta <= 1'b1;
			end
		end
	end

	// framer: half-bit check of start, then centre samples
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= RX_IDLE;
			cnt_q <= 16'h0000;
			idx_q <= 3'h0;
			sh_q <= 8'h00;
			stp_q <= 1'b0;
			fe_q <= 1'b0;
			rif.char_valid <= 1'b0;
			rif.char_data <= 8'h00;
			rif.frame_err <= 1'b0;
			rif.brk <= 1'b0;
		end else if (ce) begin
			rif.char_valid <= 1'b0;
			rif.frame_err <= 1'b0;
			rif.brk <= 1'b0;
			if (rif.clr) begin
				st_q <= RX_IDLE;
			end else if (rif.run) begin
				if (st_q != RX_IDLE && cnt_q != 16'h0000) begin
					cnt_q <= cnt_q - 16'h0001;
				end else begin
					case (st_q)
						RX_IDLE: begin
							// falling edge of the line opens a frame
							if (!lvl_q) begin
								st_q <= RX_START;
								cnt_q <= {1'b0, rif.div[15:1]};
							end
						end
						RX_START: begin
							// a start that is high again was a glitch
							st_q <= lvl_q ? RX_IDLE : RX_DATA;
							cnt_q <= rif.div;
							idx_q <= 3'h0;
						end
						RX_DATA: begin
							sh_q <= {lvl_q, sh_q[7:1]};
							cnt_q <= rif.div;
							idx_q <= idx_q + 3'h1;
							if (idx_q == LAST_BIT) begin
								st_q <= RX_STOP;
								stp_q <= rif.two_stop;
								fe_q <= 1'b0;
							end
						end
						RX_STOP: begin
							if (stp_q) begin
								stp_q <= 1'b0;
								fe_q <= !lvl_q;
								cnt_q <= rif.div;
							end else begin
								st_q <= RX_IDLE;
								rif.char_valid <= 1'b1;
								rif.char_data <= sh_q;
								rif.frame_err <= fe_q | !lvl_q;
								// all-low frame means a break on the line
								rif.brk <= !lvl_q && sh_q == 8'h00;
							end
						end
						default: st_q <= RX_IDLE;
					endcase
				end
			end
		end
	end

	a_fe_with_char:
	assert property (@(posedge hclk) disable iff (!hresetn)
		rif.frame_err |-> rif.char_valid)
	else $error("framing error without a character");
endmodule
`default_nettype wire

// ===== hw/asp_top.sv
// asp_top: async serial port with AHB-Lite register slave
// assumes: one AHB-Lite master, word accesses, hclk at 100 MHz
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
module asp_top
	import asp_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rx_pin,
	output logic tx_pin,
	input wire logic emu_halt,
	output logic async_port_irq
);
	// word match, ignoring the byte lane bits
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = a[7:2] == o[7:2];
	endfunction

	asp_rx_if rif();

	logic a_wr_q; // write pending in data phase
	logic [7:0] a_ofs_q; // its offset
	logic [15:0] ctrl_q; // async_port_control
	logic [15:0] baud_q; // bit time minus one
	logic [6:0] sts_q; // sticky events
	logic [6:0] en_q; // event enables
	logic [6:0] ev; // events this cycle
	logic [6:0] gate; // mask bits per event
	logic [6:0] pend;
	logic [15:0] iosw; // io_status_word
	logic [31:0] rd_word;
	logic acc; // address phase taken
	logic data_wr; // write into async_data_reg
	logic rd_data; // read of async_data_reg
	logic [7:0] tx_hold_q; // transmit side of async_data_reg
	logic tx_full_q;
	logic [7:0] rbuf_q; // receive side of async_data_reg
	logic drdy_q;
	logic ovr_q;
	logic fe_q;
	logic brk_q;
	logic abd_q;
	logic abd_ev; // letter a seen
	asp_tx_st_type tx_st_q;
	logic [7:0] tx_sh_q; // async_tx_shifter
	logic [15:0] bcnt_q; // clocks left in the bit
	logic [2:0] tx_idx_q;
	logic stp2_q; // second stop still to send
	logic tx_q;
	logic prst; // port held in reset
	logic idle_lvl;
	logic halt_hard; // stop at once
	logic halt_soft; // finish the character, start no new
	logic tx_load; // holding word moves to shifter
	logic tx_holding_empty;
	logic tx_all_empty;

	// ce low also stalls the bus, so no transfer is lost
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign hrdata = rd_word;
	assign tx_pin = tx_q;
	assign acc = hsel && htrans[1] && hready;
	assign data_wr = a_wr_q && hit(a_ofs_q, OFS_DATA);
	assign rd_data = acc && !hwrite && hit(haddr[7:0], OFS_DATA);

	// control decode
	assign prst = ctrl_q[CB_PRST];
	// bit set drives the line low while idle, a break
	assign idle_lvl = !ctrl_q[CB_IDLE_LVL];
	assign halt_hard = emu_halt && !ctrl_q[CB_FREE] && !ctrl_q[CB_SOFT];
	assign halt_soft = emu_halt && !ctrl_q[CB_FREE] && ctrl_q[CB_SOFT];
	assign tx_load = tx_full_q && tx_st_q == TX_IDLE && !prst &&
		!halt_hard && !halt_soft;
	assign tx_holding_empty = !tx_full_q;
	assign tx_all_empty = !tx_full_q && tx_st_q == TX_IDLE;

	// receiver settings
	assign rif.div = baud_q;
	assign rif.two_stop = ctrl_q[CB_STOP2];
	assign rif.run = !halt_hard;
	assign rif.clr = prst;

	asp_rx u_rx (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.rx_pin(rx_pin),
		.rif(rif)
	);

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_wr_q <= 1'b0;
			a_ofs_q <= 8'h00;
		end else if (ce) begin
			a_wr_q <= acc && hwrite;
			a_ofs_q <= haddr[7:0];
		end
	end

	// read mux, unmapped and write-only offsets read zero
	always_comb begin
		iosw = 16'h0000;
		iosw[SB_BRK] = brk_q;
		iosw[SB_ABD] = abd_q;
		iosw[SB_DRDY] = drdy_q;
		iosw[SB_OVR] = ovr_q;
		iosw[SB_FE] = fe_q;
		iosw[SB_THE] = tx_holding_empty;
		iosw[SB_TAE] = tx_all_empty;
		rd_word = 32'h00000000;
		if (a_wr_q) begin
			rd_word = 32'h00000000;
		end else if (hit(a_ofs_q, OFS_CTRL)) begin
			rd_word = {16'h0000, ctrl_q};
		end else if (hit(a_ofs_q, OFS_DATA)) begin
			rd_word = {24'h000000, rbuf_q};
		end else if (hit(a_ofs_q, OFS_IOSTAT)) begin
			rd_word = {16'h0000, iosw};
		end else if (hit(a_ofs_q, OFS_IRQ_STS)) begin
			rd_word = {25'h0000000, sts_q};
		end else if (hit(a_ofs_q, OFS_IRQ_EN)) begin
			rd_word = {25'h0000000, en_q};
		end else if (hit(a_ofs_q, OFS_BAUD)) begin
			rd_word = {16'h0000, baud_q};
		end
	end

	// software-written settings, taken in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q <= CTRL_RST;
			baud_q <= BAUD_RST;
			en_q <= IRQ_EN_RST;
		end else if (ce && a_wr_q) begin
			if (hit(a_ofs_q, OFS_CTRL)) begin
				ctrl_q <= hwdata[15:0];
			end
			if (hit(a_ofs_q, OFS_BAUD)) begin
				baud_q <= hwdata[15:0];
			end
			if (hit(a_ofs_q, OFS_IRQ_EN)) begin
				en_q <= hwdata[6:0];
			end
		end
	end

	// holding register: a write refills it even in the load cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_hold_q <= 8'h00;
			tx_full_q <= 1'b0;
		end else if (ce) begin
			if (data_wr) begin
				tx_hold_q <= hwdata[7:0];
				tx_full_q <= 1'b1;
			end else if (prst || tx_load) begin
				tx_full_q <= 1'b0;
			end
		end
	end

	// transmit framer; every bit lasts baud_q plus one clocks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_st_q <= TX_IDLE;
			tx_sh_q <= 8'h00;
			bcnt_q <= 16'h0000;
			tx_idx_q <= 3'h0;
			stp2_q <= 1'b0;
			tx_q <= 1'b1;
		end else if (ce) begin
			if (prst) begin
				tx_st_q <= TX_IDLE;
				tx_q <= idle_lvl;
			end else if (!halt_hard) begin
				if (tx_st_q != TX_IDLE && bcnt_q != 16'h0000) begin
					bcnt_q <= bcnt_q - 16'h0001;
				end else begin
					case (tx_st_q)
						TX_IDLE: begin
							tx_q <= idle_lvl;
							if (tx_load) begin
								tx_sh_q <= tx_hold_q;
								tx_st_q <= TX_START;
								bcnt_q <= baud_q;
								tx_q <= 1'b0;
							end
						end
						TX_START: begin
							tx_st_q <= TX_DATA;
							tx_idx_q <= 3'h0;
							bcnt_q <= baud_q;
							tx_q <= tx_sh_q[0];
						end
						TX_DATA: begin
							tx_sh_q <= {1'b0, tx_sh_q[7:1]};
							tx_idx_q <= tx_idx_q + 3'h1;
							bcnt_q <= baud_q;
							if (tx_idx_q == LAST_BIT) begin
								tx_st_q <= TX_STOP;
								stp2_q <= ctrl_q[CB_STOP2];
								tx_q <= 1'b1;
							end else begin
								tx_q <= tx_sh_q[1];
							end
						end
						TX_STOP: begin
							if (stp2_q) begin
								stp2_q <= 1'b0;
								bcnt_q <= baud_q;
							end else begin
								tx_st_q <= TX_IDLE;
								tx_q <= idle_lvl;
							end
						end
						default: tx_st_q <= TX_IDLE;
					endcase
				end
			end
		end
	end

	// receive buffer and its flags; a new event beats the read clear
	assign abd_ev = rif.char_valid &&
		(rif.char_data == ABD_UPPER || rif.char_data == ABD_LOWER);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rbuf_q <= 8'h00;
			drdy_q <= 1'b0;
			ovr_q <= 1'b0;
			fe_q <= 1'b0;
			brk_q <= 1'b0;
			abd_q <= 1'b0;
		end else if (ce) begin
			if (rd_data) begin
				drdy_q <= 1'b0;
				ovr_q <= 1'b0;
				fe_q <= 1'b0;
				brk_q <= 1'b0;
				abd_q <= 1'b0;
			end
			if (rif.char_valid) begin
				rbuf_q <= rif.char_data;
				drdy_q <= 1'b1;
				// unread character overwritten
				if (drdy_q && !rd_data) begin
					ovr_q <= 1'b1;
				end
				if (rif.frame_err) begin
					fe_q <= 1'b1;
				end
				if (rif.brk) begin
					brk_q <= 1'b1;
				end
				if (abd_ev) begin
					abd_q <= 1'b1;
				end
			end
		end
	end

	// event vector and per-event mask selection
	assign ev[IB_RXC] = rif.char_valid;
	assign ev[IB_OVR] = rif.char_valid && drdy_q && !rd_data;
	assign ev[IB_FE] = rif.frame_err;
	assign ev[IB_BRK] = rif.brk;
	assign ev[IB_ABD] = abd_ev;
	assign ev[IB_TX] = tx_load;
	assign ev[IB_DLT] = rif.delta;
	assign gate = {1'b1, ctrl_q[CB_TX_IM], {5{ctrl_q[CB_RX_IM]}}};
	assign pend = sts_q & en_q & gate;

	// sticky status, write-one-to-clear; set wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sts_q <= 7'h00;
		end else if (ce) begin
			if (a_wr_q && hit(a_ofs_q, OFS_IRQ_CLR)) begin
				sts_q <= (sts_q & ~hwdata[6:0]) | ev;
			end else begin
				sts_q <= sts_q | ev;
			end
		end
	end

	// one registered line for all sources
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			async_port_irq <= 1'b0;
		end else if (ce) begin
			async_port_irq <= |pend;
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_stop_first;
		ce && tx_st_q == TX_STOP && stp2_q && bcnt_q == 16'h0000 && !prst
			&& !halt_hard;
	endsequence
	sequence s_load;
		ce && tx_load && !halt_hard;
	endsequence

	a_start_low:
	assert property (s_load |=> !tx_q && tx_st_q == TX_START)
	else $error("start bit not low after load");
	a_two_stops:
	assert property (s_stop_first |=> tx_st_q == TX_STOP && tx_q)
	else $error("second stop bit missing");
	a_idle_level:
	assert property (ce && tx_st_q == TX_IDLE && !tx_load |=>
		tx_q == !$past(ctrl_q[CB_IDLE_LVL]))
	else $error("idle level wrong");
	a_rx_event:
	assert property (ce && rif.char_valid |=> sts_q[IB_RXC])
	else $error("received character not flagged");
	a_rx_mask:
	assert property (ce && !ctrl_q[CB_RX_IM] && (pend & ~IRQ_RX_SET) == 7'h00
		|=> !async_port_irq)
	else $error("masked receive event raised interrupt");
	a_hold_empty:
	assert property (s_load and !data_wr |=> tx_holding_empty)
	else $error("holding flag not set after load");
	a_all_empty:
	assert property (ce && data_wr |=> !tx_all_empty)
	else $error("empty flag set with data held");
	a_emu_freeze:
	assert property (ce && halt_hard && !prst |=> $stable(tx_st_q)
		&& $stable(tx_q))
	else $error("transmitter moved while halted");
	a_tx_event:
	assert property (s_load |=> sts_q[IB_TX])
	else $error("transmit event lost");
	a_overrun_set:
	assert property (ce && rif.char_valid && drdy_q && !rd_data |=> ovr_q)
	else $error("overrun not flagged");
	a_shared_irq:
	assert property (ce && pend != 7'h00 |=> async_port_irq)
	else $error("pending event without interrupt");
endmodule
`default_nettype wire

// ===== dv/asp_remote.sv
// asp_remote: remote serial device on the far side of tx_pin and rx_pin
// assumes: bit time of BT hclk periods, same as the port's divisor plus one
`timescale 1ns/100ps
`default_nettype none
module asp_remote #(
	parameter int BT = 4
) (
	input wire logic hclk,
	input wire logic tx_line,
	input wire logic two_stop,
	input wire logic en,
	output logic rx_line
);
	logic [7:0] got_q[$]; // characters decoded from the port
	int frame_errs; // bad start or stop levels seen
	// idle line high, as a pulled-up line would sit
	initial begin
		rx_line = 1'b1;
		frame_errs = 0;
	end
	// listener: start edge, then sample each bit at its centre
	always begin : listen
		logic [7:0] c;
		@(negedge tx_line);
		if (en) begin
			repeat (BT / 2) @(posedge hclk);
			if (tx_line !== 1'b0) frame_errs++;
			for (int i = 0; i < 8; i++) begin
				repeat (BT) @(posedge hclk);
				c[i] = tx_line;
			end
			repeat (BT) @(posedge hclk);
			if (tx_line !== 1'b1) frame_errs++;
			// second stop only when the port asks for it
			if (two_stop) begin
				repeat (BT) @(posedge hclk);
				if (tx_line !== 1'b1) frame_errs++;
			end
			got_q.push_back(c);
		end
	end
	// sends one character; stop_ok low forces a framing fault
	task automatic send(input logic [7:0] c, input logic stop_ok);
		@(posedge hclk);
		rx_line <= 1'b0;
		repeat (BT) @(posedge hclk);
		for (int i = 0; i < 8; i++) begin
			rx_line <= c[i];
			repeat (BT) @(posedge hclk);
		end
		rx_line <= stop_ok;
		repeat (BT) @(posedge hclk);
		rx_line <= 1'b1;
		if (two_stop) repeat (BT) @(posedge hclk);
	endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// tb_top: self-checking bench for the async serial port
// assumes: asp_top as the only AHB-Lite slave, remote model on the line
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import asp_pkg::*;
;
	localparam int BT = 4; // bit time in clocks, divisor BT-1
	logic hclk, hresetn, ce, hsel, hwrite, rx_pin, emu_halt;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, rv;
	logic hreadyout, hresp, tx_pin, irq, two_stop, listen;
	logic [31:0] hrdata;
	int failures, total_checks, cycles;
	asp_top asp_top_i (.hclk(hclk), .hresetn(hresetn), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.rx_pin(rx_pin), .tx_pin(tx_pin), .emu_halt(emu_halt),
		.async_port_irq(irq));
	asp_remote #(.BT(BT)) asp_remote_i (.hclk(hclk), .tx_line(tx_pin),
		.two_stop(two_stop), .en(listen), .rx_line(rx_pin));
	// free-running 100 MHz clock
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// hang guard, well above the whole sequence
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h want %h", $time, seen, exp);
		end
	endtask
	// one single transfer; waits on hready in both phases
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'b10;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rv = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h00000000);
		chk(rv & m, e);
	endtask
	// settle past registered outputs before looking at pins
	task automatic look(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask
	task automatic expect_tx(input logic [7:0] e);
		int k;
		for (k = 0; k < 3000 && asp_remote_i.got_q.size() == 0; k++)
			@(posedge hclk);
		if (asp_remote_i.got_q.size() == 0) begin
			chk(32'h00000001, 32'h00000000);
		end else begin
			chk({24'h0, asp_remote_i.got_q.pop_front()}, {24'h0, e});
		end
	endtask
	// reset values, unmapped and write-only reads, idle pin
	task automatic t_reset();
		rdc(OFS_CTRL, 32'h0000FFFF, 32'h00000000);
		rdc(OFS_BAUD, 32'h0000FFFF, 32'h00000363);
		rdc(OFS_IOSTAT, 32'h00001800, 32'h00001800);
		rdc(8'h1C, 32'hFFFFFFFF, 32'h00000000);
		rdc(OFS_IRQ_CLR, 32'hFFFFFFFF, 32'h00000000);
		chk(tx_pin, 1'b1);
		chk(irq, 1'b0);
	endtask
	// two characters back to back; holding full while shifter busy
	task automatic t_tx(input logic [7:0] c, input logic st2);
		two_stop <= st2;
		wr(OFS_CTRL, {25'h0, st2, 6'h00});
		wr(OFS_DATA, {24'h0, c});
		wr(OFS_DATA, {24'h0, ~c});
		rdc(OFS_IOSTAT, 32'h00001800, 32'h00000000);
		expect_tx(c);
		expect_tx(~c);
		look(4 * BT);
		rdc(OFS_IOSTAT, 32'h00001800, 32'h00001800);
		chk(32'(asp_remote_i.frame_errs), 32'h0);
	endtask
	// transmit interrupt gated by control bit 8
	task automatic t_txirq();
		wr(OFS_IRQ_EN, 32'h00000020);
		// earlier loads left the event set; start from a clean status
		wr(OFS_IRQ_CLR, 32'h00000020);
		wr(OFS_DATA, 32'h00000055);
		expect_tx(8'h55);
		look(2);
		chk(irq, 1'b0);
		rdc(OFS_IRQ_STS, 32'h00000020, 32'h00000020);
		wr(OFS_CTRL, 32'h00000100);
		look(3);
		chk(irq, 1'b1);
		// a frozen port stalls the bus and keeps its interrupt line
		@(posedge hclk);
		ce <= 1'b0;
		repeat (5) @(posedge hclk);
		chk({hreadyout, irq}, 2'b01);
		ce <= 1'b1;
		wr(OFS_IRQ_CLR, 32'h00000020);
		look(3);
		chk(irq, 1'b0);
	endtask
	// idle level follows control bit 4
	task automatic t_idle();
		listen <= 1'b0;
		wr(OFS_CTRL, 32'h00000010);
		look(3);
		chk(tx_pin, 1'b0);
		wr(OFS_CTRL, 32'h00000000);
		look(3);
		chk(tx_pin, 1'b1);
		listen <= 1'b1;
	endtask
	// receive events, mask, overrun, framing and break
	task automatic t_rx();
		wr(OFS_IRQ_EN, 32'h0000001F);
		wr(OFS_IRQ_CLR, 32'h0000007F);
		asp_remote_i.send(8'h41, 1'b1);
		look(8);
		rdc(OFS_IRQ_STS, 32'h0000001F, 32'h00000011);
		chk(irq, 1'b0);
		wr(OFS_CTRL, 32'h00000080);
		look(3);
		chk(irq, 1'b1);
		rdc(OFS_IOSTAT, 32'h00000760, 32'h00000140);
		rdc(OFS_DATA, 32'h000000FF, 32'h00000041);
		rdc(OFS_IOSTAT, 32'h00000760, 32'h00000000);
		wr(OFS_IRQ_CLR, 32'h0000007F);
		asp_remote_i.send(8'h61, 1'b1);
		asp_remote_i.send(8'h62, 1'b1);
		look(8);
		rdc(OFS_IRQ_STS, 32'h0000001F, 32'h00000013);
		rdc(OFS_IOSTAT, 32'h00000360, 32'h00000340);
		rdc(OFS_DATA, 32'h000000FF, 32'h00000062);
		wr(OFS_IRQ_CLR, 32'h0000007F);
		asp_remote_i.send(8'h5A, 1'b0);
		look(8);
		rdc(OFS_IRQ_STS, 32'h0000000E, 32'h00000004);
		rdc(OFS_IOSTAT, 32'h00000400, 32'h00000400);
		rdc(OFS_DATA, 32'h000000FF, 32'h0000005A);
		wr(OFS_IRQ_CLR, 32'h0000007F);
		asp_remote_i.send(8'h00, 1'b0);
		look(8);
		rdc(OFS_IRQ_STS, 32'h0000000C, 32'h0000000C);
		rdc(OFS_IOSTAT, 32'h00000020, 32'h00000020);
		rdc(OFS_DATA, 32'h000000FF, 32'h00000000);
	endtask
	// halt with free clear and soft clear holds transmit; free runs
	task automatic t_emu();
		wr(OFS_CTRL, 32'h00000000);
		emu_halt <= 1'b1;
		wr(OFS_DATA, 32'h00000096);
		// stay on the clock edge so the halt input moves at an edge
		repeat (20 * BT) @(posedge hclk);
		chk(32'(asp_remote_i.got_q.size()), 32'h0);
		emu_halt <= 1'b0;
		expect_tx(8'h96);
		wr(OFS_CTRL, 32'h00008000);
		emu_halt <= 1'b1;
		wr(OFS_DATA, 32'h00000069);
		expect_tx(8'h69);
		emu_halt <= 1'b0;
		// soft mode: running character finishes, the next one waits
		wr(OFS_CTRL, 32'h00004000);
		wr(OFS_DATA, 32'h000000A5);
		repeat (2) @(posedge hclk);
		emu_halt <= 1'b1;
		wr(OFS_DATA, 32'h0000005A);
		expect_tx(8'hA5);
		repeat (20 * BT) @(posedge hclk);
		chk(32'(asp_remote_i.got_q.size()), 32'h0);
		emu_halt <= 1'b0;
		expect_tx(8'h5A);
	endtask
	// main sequence: 20-cycle reset, then each scenario in turn
	initial begin
		failures = 0;
		total_checks = 0;
		cycles = 0;
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		haddr = 32'h00000000;
		hwdata = 32'h00000000;
		emu_halt = 1'b0;
		two_stop = 1'b0;
		listen = 1'b1;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		wr(OFS_BAUD, BT - 1);
		t_tx(8'hC1, 1'b0);
		t_tx(8'h3A, 1'b1);
		two_stop <= 1'b0;
		wr(OFS_CTRL, 32'h00000000);
		t_txirq();
		t_idle();
		t_rx();
		t_emu();
		wrap_up();
	end
endmodule
`default_nettype wire
